/* File: design/dioft_pkg.sv */
// constants, types and helpers shared by the discrete i/o relay fault-test block
// Summary of operation
// R1: 24 discrete inputs are sampled and each presented as one bit to software.
// R2: inputs form four groups of six, each group a contiguous slice of bits.
// R3: every input change of state is stamped with the millisecond counter.
// R4: twelve redundant relay outputs, each with latent fault testing.
// R5: each output drives six relays; a closed command asserts all six drives.
// R6: an open command deasserts all six relay drives of that output.
// R7: closed output under test: open a pair, reclose it, check both moves.
// R8: open output under test: close one relay then reopen, stepping through six.
// R9: each relay readback is compared with the expected state at every step.
// R10: a mismatch flags a fault, halts testing, and keeps the commanded state.
// R11: test steps never change the output state seen by the load.
// R12: testing is enabled per output; disabled outputs run no test steps.
// R13: latent testing of any single output can be switched off entirely.
// R14: per output, software picks whether the open or closed contact set is read back.
// R15: fault lamp lit after reset; off only when diagnostics pass, else lit or blinking.
// R16: inputs and commands refresh once per update period; tests run far slower.
// R17: each step waits a programmable settle time before readback is compared.
package dioft_pkg;
	localparam int NUM_IN     = 24;
	localparam int NUM_OUT    = 12;
	localparam int RELAYS     = 6;
	localparam int GROUPS     = 4;
	localparam int GROUP_SIZE = 6;

	localparam int CLK_PERIOD_NS    = 5;
	localparam int MS_NS            = 1000000;
	localparam int MS_CYCLES        = MS_NS / CLK_PERIOD_NS;
	localparam int UPDATE_MS        = 5;
	localparam int TEST_INTERVAL_MS = 1000;
	localparam int BLINK_BIT        = 8;

	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_DIN       = 12'h004;
	localparam logic [11:0] OFS_DOUT      = 12'h008;
	localparam logic [11:0] OFS_TEST_EN   = 12'h00c;
	localparam logic [11:0] OFS_NC_SEL    = 12'h010;
	localparam logic [11:0] OFS_SETTLE    = 12'h014;
	localparam logic [11:0] OFS_FAULT     = 12'h018;
	localparam logic [11:0] OFS_MS_COUNT  = 12'h01c;
	localparam logic [11:0] OFS_IRQ_STS   = 12'h020;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h024;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h028;
	localparam logic [11:0] OFS_STAMP     = 12'h040;
	localparam logic [11:0] OFS_STAMP_END = 12'h09c;

	localparam int CTRL_PASS_BIT  = 0;
	localparam int CTRL_BLINK_BIT = 1;
	localparam int IRQ_FAULT_BIT  = 4;
	localparam int IRQ_W          = 5;

	localparam logic [7:0] SETTLE_RESET = 8'h0f;

	typedef enum logic [1:0] {TS_IDLE, TS_TOGGLE, TS_RESTORE, TS_HALT} dioft_test_state_e;

	// relays 2k and 2k+1 sit in one parallel branch, so opening both keeps the path closed
	function automatic logic [5:0] pair_mask(input logic [2:0] step);
		unique case (step)
			3'h0, 3'h3: pair_mask = 6'h03;
			3'h1, 3'h4: pair_mask = 6'h0c;
			default:    pair_mask = 6'h30;
		endcase
	endfunction

	function automatic logic rb_match(input logic [5:0] drv, input logic [5:0] rb,
		input logic nc);
		rb_match = (rb == (nc ? ~drv : drv));
	endfunction
endpackage

/* File: design/dioft_chan_if.sv */
// per-output link between the register block and one relay test engine
interface dioft_chan_if;
	logic       cmd;
	logic       test_en;
	logic       nc_sel;
	logic       step_tick;
	logic       ms_tick;
	logic [7:0] settle_ms;
	logic [5:0] readback;
	logic [5:0] drive;
	logic       fault;

	modport tester (input cmd, test_en, nc_sel, step_tick, ms_tick, settle_ms, readback,
		output drive, fault);
	modport ctl (output cmd, test_en, nc_sel, step_tick, ms_tick, settle_ms, readback,
		input drive, fault);
endinterface

/* File: design/dioft_relay_test.sv */
// latent fault test engine and relay drive for one six-relay output
module dioft_relay_test (
	input wire logic             pclk,
	input wire logic             presetn,
	dioft_chan_if.tester         link
);
	dioft_pkg::dioft_test_state_e state_ff, nxt_state;
	logic [2:0]                   step_ff, nxt_step;
	logic [7:0]                   wait_ff, nxt_wait;
	logic [5:0]                   mask_ff, nxt_mask;
	logic [5:0]                   drive_ff, nxt_drive;
	logic                         tcmd_ff, nxt_tcmd;
	logic                         fault_ff, nxt_fault;
	logic                         rb_ok;
	logic                         last_step;

	assign rb_ok = dioft_pkg::rb_match(drive_ff, link.readback, link.nc_sel); // [R9] [R14]
	assign last_step = tcmd_ff ? (step_ff >= 3'h2) : (step_ff >= 3'h5);

	always_comb begin
		nxt_state = state_ff;
		nxt_step  = step_ff;
		nxt_wait  = wait_ff;
		nxt_mask  = mask_ff;
		nxt_tcmd  = tcmd_ff;
		nxt_fault = fault_ff;
		unique case (state_ff)
			dioft_pkg::TS_IDLE: begin
				nxt_mask = '0;
				if (link.step_tick && link.test_en) begin // [R12] [R13] [R16]
					nxt_mask  = link.cmd ? dioft_pkg::pair_mask(step_ff) // [R7]
						: (6'h01 << step_ff); // [R8]
					nxt_tcmd  = link.cmd;
					nxt_wait  = link.settle_ms; // [R17]
					nxt_state = dioft_pkg::TS_TOGGLE;
				end
			end
			dioft_pkg::TS_TOGGLE, dioft_pkg::TS_RESTORE: begin
				// a new command or a disable abandons the step so the command wins at once
				if (link.cmd != tcmd_ff || !link.test_en) begin
					nxt_mask  = '0;
					nxt_state = dioft_pkg::TS_IDLE;
				end else if (link.ms_tick) begin
					if (wait_ff != 8'h00) begin
						nxt_wait = wait_ff - 8'h01; // [R17]
					end else if (!rb_ok) begin
						nxt_fault = 1'b1; // [R10]
						nxt_mask  = '0;
						nxt_state = dioft_pkg::TS_HALT;
					end else if (state_ff == dioft_pkg::TS_TOGGLE) begin
						nxt_mask  = '0;
						nxt_wait  = link.settle_ms;
						nxt_state = dioft_pkg::TS_RESTORE;
					end else begin
						nxt_step  = last_step ? 3'h0 : step_ff + 3'h1;
						nxt_state = dioft_pkg::TS_IDLE;
					end
				end
			end
			dioft_pkg::TS_HALT: begin
				nxt_mask = '0;
				if (!link.test_en) begin
					nxt_fault = 1'b0;
					nxt_state = dioft_pkg::TS_IDLE;
				end
			end
		endcase
		nxt_drive = {6{link.cmd}} ^ nxt_mask; // [R5] [R6] [R11]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= dioft_pkg::TS_IDLE;
			step_ff  <= 3'h0;
			wait_ff  <= 8'h00;
			mask_ff  <= 6'h00;
			drive_ff <= 6'h00;
			tcmd_ff  <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			step_ff  <= nxt_step;
			wait_ff  <= nxt_wait;
			mask_ff  <= nxt_mask;
			drive_ff <= nxt_drive;
			tcmd_ff  <= nxt_tcmd;
			fault_ff <= nxt_fault;
		end
	end

	assign link.drive = drive_ff;
	assign link.fault = fault_ff;

	toggle_count_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7] [R8] [R11]
		(state_ff == dioft_pkg::TS_TOGGLE && link.cmd == tcmd_ff) |->
		$countones(drive_ff ^ {6{tcmd_ff}}) == (tcmd_ff ? 2 : 1))
		else $error("test step moved the wrong number of relays");
	mismatch_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9] [R10]
		(state_ff != dioft_pkg::TS_IDLE && state_ff != dioft_pkg::TS_HALT && link.ms_tick
		&& wait_ff == 8'h00 && !rb_ok && link.cmd == tcmd_ff && link.test_en)
		|=> fault_ff && state_ff == dioft_pkg::TS_HALT)
		else $error("readback mismatch did not halt testing");
	halt_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		state_ff == dioft_pkg::TS_HALT ##1 state_ff == dioft_pkg::TS_HALT
		|-> drive_ff == {6{$past(link.cmd)}})
		else $error("halted output does not follow its command");
	no_test_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12] [R13]
		!link.test_en ##1 !link.test_en |-> mask_ff == 6'h00)
		else $error("relay toggled while testing disabled");
	cover property (@(posedge pclk) disable iff (!presetn) $rose(fault_ff));
	cover property (@(posedge pclk) disable iff (!presetn)
		state_ff == dioft_pkg::TS_RESTORE && tcmd_ff ##1 state_ff == dioft_pkg::TS_IDLE);
endmodule

/* File: design/dioft_top.sv */
// discrete input capture, relay outputs and latent fault test with apb registers
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
module dioft_top #(
	parameter int unsigned MS_CYCLES = dioft_pkg::MS_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [23:0] din_raw,
	input  wire logic [71:0] relay_readback,
	output logic      [71:0] relay_drive,
	output logic             irq,
	output logic             fault_led
);
	localparam int NI = dioft_pkg::NUM_IN;
	localparam int NO = dioft_pkg::NUM_OUT;
	localparam int IW = dioft_pkg::IRQ_W;

	// timebase: millisecond tick, update tick and test step tick
	logic [19:0]   pre_ff, nxt_pre;
	logic [15:0]   ms_cnt_ff, nxt_ms_cnt;
	logic [2:0]    upd_cnt_ff, nxt_upd_cnt;
	logic [9:0]    tst_cnt_ff, nxt_tst_cnt;
	logic          ms_tick_ff, nxt_ms_tick;
	logic          upd_tick_ff, nxt_upd_tick;
	logic          step_tick_ff, nxt_step_tick;
	logic [NI-1:0] smp_ff, nxt_smp;
	logic [NI-1:0] din_ff, nxt_din;
	logic [NI-1:0] chg;
	logic [15:0]   stamp_ff [NI];
	logic [15:0]   nxt_stamp [NI];

	always_comb begin
		nxt_ms_tick   = (pre_ff == 20'(MS_CYCLES - 1));
		nxt_pre       = nxt_ms_tick ? 20'h0_0000 : pre_ff + 20'h0_0001;
		nxt_ms_cnt    = ms_cnt_ff;
		nxt_upd_cnt   = upd_cnt_ff;
		nxt_tst_cnt   = tst_cnt_ff;
		nxt_upd_tick  = 1'b0;
		nxt_step_tick = 1'b0;
		nxt_smp       = smp_ff;
		nxt_din       = din_ff;
		nxt_stamp     = stamp_ff;
		chg           = '0;
		if (ms_tick_ff) begin
			nxt_ms_cnt = ms_cnt_ff + 16'h0001;
			nxt_smp    = din_raw;
			chg        = din_raw ^ smp_ff;
			for (int i = 0; i < NI; i++) begin
				if (chg[i]) begin
					nxt_stamp[i] = ms_cnt_ff; // [R3]
				end
			end
			if (upd_cnt_ff == 3'(dioft_pkg::UPDATE_MS - 1)) begin
				nxt_upd_cnt  = 3'h0;
				nxt_upd_tick = 1'b1; // [R16]
			end else begin
				nxt_upd_cnt = upd_cnt_ff + 3'h1;
			end
			if (tst_cnt_ff == 10'(dioft_pkg::TEST_INTERVAL_MS - 1)) begin
				nxt_tst_cnt   = 10'h000;
				nxt_step_tick = 1'b1; // [R16]
			end else begin
				nxt_tst_cnt = tst_cnt_ff + 10'h001;
			end
		end
		if (upd_tick_ff) begin
			nxt_din = smp_ff; // [R1] [R16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff       <= 20'h0_0000;
			ms_cnt_ff    <= 16'h0000;
			upd_cnt_ff   <= 3'h0;
			tst_cnt_ff   <= 10'h000;
			ms_tick_ff   <= 1'b0;
			upd_tick_ff  <= 1'b0;
			step_tick_ff <= 1'b0;
			smp_ff       <= '0;
			din_ff       <= '0;
			for (int i = 0; i < NI; i++) begin
				stamp_ff[i] <= 16'h0000;
			end
		end else begin
			pre_ff       <= nxt_pre;
			ms_cnt_ff    <= nxt_ms_cnt;
			upd_cnt_ff   <= nxt_upd_cnt;
			tst_cnt_ff   <= nxt_tst_cnt;
			ms_tick_ff   <= nxt_ms_tick;
			upd_tick_ff  <= nxt_upd_tick;
			step_tick_ff <= nxt_step_tick;
			smp_ff       <= nxt_smp;
			din_ff       <= nxt_din;
			stamp_ff     <= nxt_stamp;
		end
	end

	// per-group change events: group g owns input bits 6g..6g+5
	logic [dioft_pkg::GROUPS-1:0] grp_chg;
	for (genvar g = 0; g < dioft_pkg::GROUPS; g++) begin : g_grp
		assign grp_chg[g] = |chg[g*dioft_pkg::GROUP_SIZE +: dioft_pkg::GROUP_SIZE]; // [R2]
	end

	// relay outputs: one test engine per output
	logic [NO-1:0] fault_vec;
	logic [NO-1:0] cmd_ff, nxt_cmd;
	logic [NO-1:0] cmd_upd_ff, nxt_cmd_upd;
	logic [NO-1:0] ten_ff, nxt_ten;
	logic [NO-1:0] nc_ff, nxt_nc;
	logic [7:0]    settle_ff, nxt_settle;
	dioft_chan_if  ch_if [NO] ();

	for (genvar c = 0; c < NO; c++) begin : g_out
		assign ch_if[c].cmd       = cmd_upd_ff[c];
		assign ch_if[c].test_en   = ten_ff[c]; // [R12] [R13]
		assign ch_if[c].nc_sel    = nc_ff[c]; // [R14]
		assign ch_if[c].step_tick = step_tick_ff;
		assign ch_if[c].ms_tick   = ms_tick_ff;
		assign ch_if[c].settle_ms = settle_ff; // [R17]
		assign ch_if[c].readback  = relay_readback[c*6 +: 6];
		assign relay_drive[c*6 +: 6] = ch_if[c].drive; // [R4]
		assign fault_vec[c]       = ch_if[c].fault;
		dioft_relay_test u_test (
			.pclk    (pclk),
			.presetn (presetn),
			.link    (ch_if[c].tester)
		);
		chan_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
			!ten_ff[c] ##1 !ten_ff[c] ##1 $stable(cmd_upd_ff[c])
			|-> relay_drive[c*6 +: 6] == {6{cmd_upd_ff[c]}})
			else $error("untested output drive does not follow its command");
	end

	// register file and apb slave
	logic [1:0]    ctrl_ff, nxt_ctrl;
	logic [IW-1:0] ists_ff, nxt_ists;
	logic [IW-1:0] ien_ff, nxt_ien;
	logic [IW-1:0] ev;
	logic [NO-1:0] fault_q_ff, nxt_fault_q;
	logic          irq_ff, nxt_irq;
	logic          led_ff, nxt_led;
	logic [31:0]   prdata_ff, nxt_prdata;
	logic          pready_ff, nxt_pready;
	logic          pslverr_ff, nxt_pslverr;
	logic          setup;
	logic          wr;

	function automatic logic is_stamp(input logic [11:0] a);
		is_stamp = (a >= dioft_pkg::OFS_STAMP) && (a <= dioft_pkg::OFS_STAMP_END)
			&& (a[1:0] == 2'h0);
	endfunction

	assign setup = psel && !penable;
	assign wr    = psel && penable && pready_ff && pwrite;
	assign ev    = {|(fault_vec & ~fault_q_ff), grp_chg};

	always_comb begin
		logic [11:0] sidx;
		sidx        = (paddr - dioft_pkg::OFS_STAMP) >> 2;
		nxt_ctrl    = ctrl_ff;
		nxt_cmd     = cmd_ff;
		nxt_ten     = ten_ff;
		nxt_nc      = nc_ff;
		nxt_settle  = settle_ff;
		nxt_ien     = ien_ff;
		nxt_ists    = ists_ff;
		nxt_fault_q = fault_vec;
		nxt_prdata  = prdata_ff;
		nxt_pready  = setup;
		nxt_pslverr = 1'b0;
		nxt_cmd_upd = upd_tick_ff ? cmd_ff : cmd_upd_ff; // [R16]
		if (wr) begin
			unique case (paddr)
				dioft_pkg::OFS_CTRL:    nxt_ctrl   = pwdata[1:0];
				dioft_pkg::OFS_DOUT:    nxt_cmd    = pwdata[NO-1:0];
				dioft_pkg::OFS_TEST_EN: nxt_ten    = pwdata[NO-1:0];
				dioft_pkg::OFS_NC_SEL:  nxt_nc     = pwdata[NO-1:0];
				dioft_pkg::OFS_SETTLE:  nxt_settle = pwdata[7:0];
				dioft_pkg::OFS_IRQ_CLR: nxt_ists   = ists_ff & ~pwdata[IW-1:0];
				dioft_pkg::OFS_IRQ_EN:  nxt_ien    = pwdata[IW-1:0];
				default:                nxt_ists   = ists_ff;
			endcase
		end
		// a new event in the clearing cycle survives the clear
		nxt_ists = nxt_ists | ev;
		if (setup) begin
			nxt_prdata = 32'h0000_0000;
			unique case (paddr)
				dioft_pkg::OFS_CTRL:     nxt_prdata[1:0]    = ctrl_ff;
				dioft_pkg::OFS_DIN:      nxt_prdata[NI-1:0] = din_ff; // [R1] [R2]
				dioft_pkg::OFS_DOUT:     nxt_prdata[NO-1:0] = cmd_ff;
				dioft_pkg::OFS_TEST_EN:  nxt_prdata[NO-1:0] = ten_ff;
				dioft_pkg::OFS_NC_SEL:   nxt_prdata[NO-1:0] = nc_ff;
				dioft_pkg::OFS_SETTLE:   nxt_prdata[7:0]    = settle_ff;
				dioft_pkg::OFS_FAULT:    nxt_prdata[NO-1:0] = fault_vec; // [R10]
				dioft_pkg::OFS_MS_COUNT: nxt_prdata[15:0]   = ms_cnt_ff;
				dioft_pkg::OFS_IRQ_STS:  nxt_prdata[IW-1:0] = ists_ff;
				dioft_pkg::OFS_IRQ_CLR:  nxt_prdata         = 32'h0000_0000;
				dioft_pkg::OFS_IRQ_EN:   nxt_prdata[IW-1:0] = ien_ff;
				default: begin
					if (is_stamp(paddr)) begin
						nxt_prdata[15:0] = stamp_ff[sidx[4:0]]; // [R3]
					end else begin
						nxt_pslverr = 1'b1;
					end
				end
			endcase
		end
		nxt_irq = |(nxt_ists & nxt_ien);
		// lamp lit, or blinking when CTRL_BLINK_BIT is set, from reset until software reports passed diagnostics
		nxt_led = !nxt_ctrl[dioft_pkg::CTRL_PASS_BIT] && // [R15]
			(!nxt_ctrl[dioft_pkg::CTRL_BLINK_BIT] || ms_cnt_ff[dioft_pkg::BLINK_BIT]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff    <= 2'h0;
			cmd_ff     <= '0;
			cmd_upd_ff <= '0;
			ten_ff     <= '0;
			nc_ff      <= '0;
			settle_ff  <= dioft_pkg::SETTLE_RESET;
			ists_ff    <= '0;
			ien_ff     <= '0;
			fault_q_ff <= '0;
			irq_ff     <= 1'b0;
			led_ff     <= 1'b1;
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			ctrl_ff    <= nxt_ctrl;
			cmd_ff     <= nxt_cmd;
			cmd_upd_ff <= nxt_cmd_upd;
			ten_ff     <= nxt_ten;
			nc_ff      <= nxt_nc;
			settle_ff  <= nxt_settle;
			ists_ff    <= nxt_ists;
			ien_ff     <= nxt_ien;
			fault_q_ff <= nxt_fault_q;
			irq_ff     <= nxt_irq;
			led_ff     <= nxt_led;
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	assign prdata    = prdata_ff;
	assign pready    = pready_ff;
	assign pslverr   = pslverr_ff;
	assign irq       = irq_ff;
	assign fault_led = led_ff;

	din_update_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1] [R16]
		upd_tick_ff |=> din_ff == $past(smp_ff))
		else $error("input word not refreshed on update tick");
	din_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		!upd_tick_ff |=> $stable(din_ff) && $stable(cmd_upd_ff))
		else $error("inputs or commands moved between update ticks");
	stamp_time_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		ms_tick_ff && chg[0] |=> stamp_ff[0] == ms_cnt_ff - 16'h0001)
		else $error("input change stamped with wrong time");
	led_pass_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		ctrl_ff[dioft_pkg::CTRL_PASS_BIT] == 1'b0 && !ctrl_ff[dioft_pkg::CTRL_BLINK_BIT]
		&& !wr |=> fault_led)
		else $error("fault lamp off before diagnostics passed");
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("apb answer not one cycle after setup");
	drive_cmd_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5] [R6]
		ten_ff == '0 ##1 ten_ff == '0 ##1 $stable(cmd_upd_ff)
		|-> relay_drive[5:0] == {6{cmd_upd_ff[0]}})
		else $error("untested output drive differs from its command");
	// status bits are sticky: an event is never lost to a clear in the same cycle
	sts_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		ev != '0 |=> (ists_ff & $past(ev)) == $past(ev))
		else $error("interrupt event lost");
	fault_irq_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
		|(fault_vec & ~fault_q_ff) |=> ists_ff[dioft_pkg::IRQ_FAULT_BIT])
		else $error("new relay fault did not set its status bit");
	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |(ists_ff & ien_ff))
		else $error("interrupt line disagrees with enabled status");
	slverr_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response without ready");
	for (genvar i = 0; i < NI; i++) begin : g_stamp_chk
		stamp_each_a: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
			ms_tick_ff && chg[i] |=> stamp_ff[i] == ms_cnt_ff - 16'h0001)
			else $error("input change stamped with a wrong time");
	end
	cover property (@(posedge pclk) disable iff (!presetn) ms_tick_ff && |chg);
	cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
	cover property (@(posedge pclk) disable iff (!presetn) $fell(fault_led));
endmodule

/* File: tb/dioft_field_model.sv */
// field side of the outputs: relay contacts read back with pickup delay and stuck-open faults
module dioft_field_model #(
	parameter int DELAY = 3
) (
	input  wire logic [71:0] relay_drive,
	input  wire logic        pclk,
	input  wire logic [11:0] nc_sel,
	input  wire logic [71:0] stuck_open,
	output logic      [71:0] relay_readback
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [71:0] pipe [DELAY];
	logic [71:0] contact;

	// contacts lag the coil drive, so readback is never true in the same cycle
	always @(posedge pclk) begin
		pipe[0] <= relay_drive;
		for (int i = 1; i < DELAY; i++) begin
			pipe[i] <= pipe[i-1];
		end
	end

	always_comb begin
		for (int c = 0; c < 12; c++) begin
			contact[6*c +: 6] = pipe[DELAY-1][6*c +: 6] & ~stuck_open[6*c +: 6];
			relay_readback[6*c +: 6] = nc_sel[c] ? ~contact[6*c +: 6] : contact[6*c +: 6];
		end
	end
endmodule

/* File: tb/dioft_top_bench.sv */
// self-checking bench for the discrete i/o relay fault-test block over apb
module dioft_top_bench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int MSC = 10;

	logic        pclk;
	logic        presetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [23:0] din_raw;
	logic [71:0] relay_readback;
	logic [71:0] relay_drive;
	logic        irq;
	logic        fault_led;
	logic [11:0] nc_cfg;
	logic [71:0] stuck_open;
	logic        mon_on;
	logic [5:0]  seen0;
	logic [5:0]  seen1;
	int          bad_count;
	int          err_total;
	int          check_count;
	logic [31:0] r0;
	logic [31:0] s0;
	logic        e0;
	logic        led0;

	dioft_top #(.MS_CYCLES(MSC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .din_raw(din_raw), .relay_readback(relay_readback),
		.relay_drive(relay_drive), .irq(irq), .fault_led(fault_led));

	dioft_field_model fm (.relay_drive(relay_drive), .pclk(pclk), .nc_sel(nc_cfg),
		.stuck_open(stuck_open), .relay_readback(relay_readback));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic stop_test();
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		psel    <= 1'b1;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		// a slave that never answers is ended by the watchdog, not here
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb_xfer(a, 1'b1, d, r, e);
		chk({31'h0, e}, 32'h0000_0000);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb_xfer(a, 1'b0, 32'h0000_0000, r, e);
		chk(r, exp);
	endtask

	task automatic wait_ms(input int n);
		repeat (n * MSC) @(posedge pclk);
	endtask

	function automatic logic legal(input logic [5:0] d, input logic closed);
		if (closed)
			legal = (d == 6'h3f) || (d == 6'h3c) || (d == 6'h33) || (d == 6'h0f);
		else
			legal = ($countones(d) <= 1);
	endfunction

	// watches the load side continuously while ch0 is closed, ch1 open, ch2 closed untested
	always @(posedge pclk) begin
		if (mon_on) begin
			if (!legal(relay_drive[5:0], 1'b1) || !legal(relay_drive[11:6], 1'b0)
				|| relay_drive[17:12] !== 6'h3f)
				bad_count <= bad_count + 1;
			seen0 <= seen0 | ~relay_drive[5:0];
			seen1 <= seen1 | relay_drive[11:6];
		end else begin
			bad_count <= 0;
			seen0     <= 6'h00;
			seen1     <= 6'h00;
		end
	end

	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		din_raw = 24'h00_0000;
		nc_cfg = 12'h000;
		stuck_open = '0;
		mon_on = 1'b0;
		err_total = 0;
		check_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({31'h0, fault_led}, 32'h0000_0001);
		chk(relay_drive[31:0], 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_chk(dioft_pkg::OFS_SETTLE, 32'h0000_000f);
		rd_chk(dioft_pkg::OFS_FAULT, 32'h0000_0000);
		apb_xfer(12'h030, 1'b0, 32'h0000_0000, r0, e0);
		chk({31'h0, e0}, 32'h0000_0001);
		wr(dioft_pkg::OFS_DIN, 32'h00ff_ffff);
		rd_chk(dioft_pkg::OFS_DIN, 32'h0000_0000);
		rd_chk(dioft_pkg::OFS_IRQ_CLR, 32'h0000_0000);
		wr(dioft_pkg::OFS_IRQ_EN, 32'h0000_001f);
		// one contact per group, all changing at once
		apb_xfer(dioft_pkg::OFS_MS_COUNT, 1'b0, 32'h0000_0000, r0, e0);
		@(posedge pclk);
		din_raw <= 24'h04_1041;
		wait_ms(12);
		rd_chk(dioft_pkg::OFS_DIN, 32'h0004_1041);
		rd_chk(dioft_pkg::OFS_IRQ_STS, 32'h0000_000f);
		chk({31'h0, irq}, 32'h0000_0001);
		apb_xfer(dioft_pkg::OFS_STAMP, 1'b0, 32'h0000_0000, s0, e0);
		chk({31'h0, (s0[15:0] - r0[15:0]) <= 16'h0002}, 32'h0000_0001);
		for (int g = 1; g < 4; g++)
			rd_chk(dioft_pkg::OFS_STAMP + 12'(24 * g), s0);
		rd_chk(dioft_pkg::OFS_STAMP + 12'h004, 32'h0000_0000);
		wr(dioft_pkg::OFS_IRQ_CLR, 32'h0000_000f);
		rd_chk(dioft_pkg::OFS_IRQ_STS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		// outputs: ch0 closed with nc readback, ch1 open, ch2 closed but never tested
		nc_cfg <= 12'h001;
		wr(dioft_pkg::OFS_NC_SEL, 32'h0000_0001);
		wr(dioft_pkg::OFS_SETTLE, 32'h0000_0001);
		wr(dioft_pkg::OFS_DOUT, 32'h0000_0005);
		wait_ms(12);
		chk({14'h0, relay_drive[17:0]}, 32'h0003_f03f);
		mon_on <= 1'b1;
		wr(dioft_pkg::OFS_TEST_EN, 32'h0000_0003);
		wait_ms(1100);
		chk({26'h0, seen0}, 32'h0000_0003);
		chk({26'h0, seen1}, 32'h0000_0001);
		rd_chk(dioft_pkg::OFS_FAULT, 32'h0000_0000);
		// ch1 relays never pick up: the next closing step must flag it
		stuck_open[11:6] <= 6'h3f;
		wait_ms(1100);
		rd_chk(dioft_pkg::OFS_FAULT, 32'h0000_0002);
		rd_chk(dioft_pkg::OFS_IRQ_STS, 32'h0000_0010);
		chk({31'h0, irq}, 32'h0000_0001);
		chk({26'h0, relay_drive[11:6]}, 32'h0000_0000);
		chk(bad_count, 32'h0000_0000);
		wr(dioft_pkg::OFS_TEST_EN, 32'h0000_0001);
		rd_chk(dioft_pkg::OFS_FAULT, 32'h0000_0000);
		wr(dioft_pkg::OFS_IRQ_EN, 32'h0000_0000);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(dioft_pkg::OFS_IRQ_CLR, 32'h0000_001f);
		rd_chk(dioft_pkg::OFS_IRQ_STS, 32'h0000_0000);
		chk({31'h0, fault_led}, 32'h0000_0001);
		// a blinking lamp flips once every 2**BLINK_BIT ms until diagnostics pass
		wr(dioft_pkg::OFS_CTRL, 32'h0000_0002);
		repeat (2) @(posedge pclk);
		led0 = fault_led;
		wait_ms(1 << dioft_pkg::BLINK_BIT);
		chk({31'h0, fault_led ^ led0}, 32'h0000_0001);
		wr(dioft_pkg::OFS_CTRL, 32'h0000_0001);
		repeat (3) @(posedge pclk);
		chk({31'h0, fault_led}, 32'h0000_0000);
		stop_test();
	end
endmodule
